// ---- pdw_pkg.sv ----
package pdw_pkg;
   localparam logic [15:0] PDW_WIN_BASE      = 16'hF400;
   localparam int          PDW_WIN_BYTES     = 1024;
   localparam int          PDW_WIN_AW        = 10;
   localparam int          PDW_MAX_HOSTS     = 4;
   localparam int          PDW_HOST_IDW      = 2;
   localparam int          PDW_FRAME_MIN     = 16;
   localparam int          PDW_FRAME_MAX     = 512;
   localparam logic [2:0]  PDW_FRAME_CODE_RST = 3'h0;
   localparam logic [7:0]  PDW_VEC_RST       = 8'h00;
   localparam logic [9:0]  PDW_CNT_RST       = 10'h000;
   localparam logic [7:0]  PDW_DATA_RST      = 8'h00;

   // Frame size code 0..5 -> 16,32,64,128,256,512 bytes
   function automatic logic [9:0] pdw_frame_bytes(input logic [2:0] code);
      logic [2:0] c;
      c = (code > 3'h5) ? 3'h5 : code;
      pdw_frame_bytes = 10'(PDW_FRAME_MIN) << c;
   endfunction
endpackage

// ---- pdw_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface pdw_if;
   import pdw_pkg::*;
   logic                   cyc;
   logic [1:0]             host_id;
   logic                   vec_we;
   logic                   mem_req;
   logic                   mem_we;
   logic [15:0]            addr;
   logic [7:0]             wdata;
   logic [7:0]             rdata;
   logic                   rdata_oe_n;
   logic                   ack;

   modport device (
      input  cyc, host_id, vec_we, mem_req, mem_we, addr, wdata,
      output rdata, rdata_oe_n, ack
   );
   modport host (
      output cyc, host_id, vec_we, mem_req, mem_we, addr, wdata,
      input  rdata, rdata_oe_n, ack
   );
endinterface
`default_nettype wire

// ---- pdw_device.sv ----
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - 1024-byte window at bus address F400H
// - All data passes through dual-port RAM
// - Answer only when vector equals own page
// - Host writes page number before window access
// - Switch page number is the interface number
// - Each module in rack has distinct page
// - One frame per cycle, 16 to 512 bytes
// - Longer transfers split over several cycles
// - Up to four host CPUs supported
// - Interface number is byte 0 to 255
module pdw_device
(
   input  wire logic                          mclk_i,
   input  wire logic                          sys_rst_i,
   pdw_if.device                              bus,
   input  wire logic [7:0]                    page_switch_i,
   input  wire logic [2:0]                    frame_code_i,
   input  wire logic                          loc_req_i,
   input  wire logic                          loc_we_i,
   input  wire logic [pdw_pkg::PDW_WIN_AW-1:0] loc_addr_i,
   input  wire logic [7:0]                    loc_wdata_i,
   output logic [7:0]                         loc_rdata_o,
   output logic                               loc_ack_o,
   output logic [pdw_pkg::PDW_MAX_HOSTS-1:0]  frame_done_o
);
   import pdw_pkg::*;

   typedef struct packed {
      logic [7:0]                   vec;
      logic [7:0]                   page;
      logic [7:0]                   sw1;
      logic [7:0]                   sw2;
      logic [7:0]                   sw3;
      logic [7:0]                   rdata;
      logic                         ack;
      logic                         drive;
      logic [7:0]                   lrdata;
      logic                         lack;
      logic                         host_pri;
      logic [PDW_MAX_HOSTS-1:0][9:0] cnt;
      logic [PDW_MAX_HOSTS-1:0]     done;
   } pdw_dev_s;

   pdw_dev_s         st_reg;
   pdw_dev_s         st_next;
   logic [7:0]       ram [PDW_WIN_BYTES];
   logic             hit;
   logic             host_go;
   logic             loc_go;
   logic             frame_full;
   logic [9:0]       fbytes;

   always_comb
   begin
      fbytes     = pdw_frame_bytes(frame_code_i);
      frame_full = st_reg.cnt[bus.host_id] >= fbytes;
      hit        = bus.mem_req && bus.cyc && (st_reg.vec == st_reg.page)
                   && (bus.addr[15:PDW_WIN_AW] == PDW_WIN_BASE[15:PDW_WIN_AW])
                   && !st_reg.ack && !frame_full;
      // Alternate priority on collision so neither port starves
      host_go    = hit && (!loc_req_i || st_reg.host_pri || st_reg.lack);
      loc_go     = loc_req_i && !st_reg.lack && !host_go;
   end

   always_comb
   begin
      st_next          = st_reg;
      st_next.ack      = host_go;
      st_next.drive    = host_go && !bus.mem_we;
      st_next.lack     = loc_go;
      st_next.done     = '0;
      // Switch pins are asynchronous; a new page counts once two stages agree
      st_next.sw1      = page_switch_i;
      st_next.sw2      = st_reg.sw1;
      st_next.sw3      = st_reg.sw2;
      if (st_reg.sw2 == st_reg.sw3)
      begin
         st_next.page = st_reg.sw3;
      end
      if (bus.vec_we && bus.cyc)
      begin
         st_next.vec = bus.wdata;
      end
      if (loc_req_i && hit)
      begin
         st_next.host_pri = !host_go;
      end
      if (host_go)
      begin
         if (!bus.mem_we)
         begin
            st_next.rdata = ram[bus.addr[PDW_WIN_AW-1:0]];
         end
         st_next.cnt[bus.host_id] = st_reg.cnt[bus.host_id] + 10'h001;
      end
      if (loc_go && !loc_we_i)
      begin
         st_next.lrdata = ram[loc_addr_i];
      end
      // End of host cycle closes the frame; rest follows next cycle
      for (int h = 0; h < PDW_MAX_HOSTS; h++)
      begin
         if (!bus.cyc && st_reg.cnt[h] != PDW_CNT_RST)
         begin
            st_next.cnt[h]  = PDW_CNT_RST;
            st_next.done[h] = 1'b1;
         end
      end
      if (sys_rst_i)
      begin
         st_next          = '0;
         st_next.vec      = PDW_VEC_RST;
         st_next.host_pri = 1'b1;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      st_reg <= st_next;
   end

   always_ff @(posedge mclk_i)
   begin
      if (!sys_rst_i && host_go && bus.mem_we)
      begin
         ram[bus.addr[PDW_WIN_AW-1:0]] <= bus.wdata;
      end
      else if (!sys_rst_i && loc_go && loc_we_i)
      begin
         ram[loc_addr_i] <= loc_wdata_i;
      end
   end

   assign bus.rdata      = st_reg.rdata;
   assign bus.rdata_oe_n = !st_reg.drive;
   assign bus.ack        = st_reg.ack;
   assign loc_rdata_o    = st_reg.lrdata;
   assign loc_ack_o      = st_reg.lack;
   assign frame_done_o   = st_reg.done;
endmodule
`default_nettype wire

// ---- pdw_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module pdw_host
(
   input  wire logic                          mclk_i,
   input  wire logic                          sys_rst_i,
   pdw_if.host                                bus,
   input  wire logic [1:0]                    host_id_i,
   input  wire logic                          start_i,
   input  wire logic                          write_i,
   input  wire logic [7:0]                    interface_number_i,
   input  wire logic [pdw_pkg::PDW_WIN_AW-1:0] offset_i,
   input  wire logic [10:0]                   length_i,
   input  wire logic [2:0]                    frame_code_i,
   input  wire logic [7:0]                    wr_data_i,
   output logic                               wr_take_o,
   output logic [7:0]                         rd_data_o,
   output logic                               rd_valid_o,
   output logic                               busy_o,
   output logic                               done_o
);
   import pdw_pkg::*;

   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_VEC  = 5'b00010,
      S_XFER = 5'b00100,
      S_GAP  = 5'b01000,
      S_DONE = 5'b10000
   } pdw_hst_e;

   typedef struct packed {
      pdw_hst_e                st;
      logic                    we;
      logic [7:0]              page;
      logic [PDW_WIN_AW-1:0]   addr;
      logic [10:0]             left;
      logic [9:0]              fcnt;
      logic                    pend;
      logic [7:0]              rdata;
      logic                    rvalid;
   } pdw_hst_s;

   pdw_hst_s     st_reg;
   pdw_hst_s     st_next;
   logic [9:0]   fbytes;
   logic         issue;

   always_comb
   begin
      fbytes  = pdw_frame_bytes(frame_code_i);
      st_next = st_reg;
      st_next.rvalid = 1'b0;
      issue   = (st_reg.st == S_XFER) && !st_reg.pend && st_reg.left != 11'h000
                && st_reg.fcnt < fbytes;
      unique case (st_reg.st)
         S_IDLE:
         begin
            if (start_i && length_i != 11'h000)
            begin
               st_next.we   = write_i;
               st_next.page = interface_number_i;
               st_next.addr = offset_i;
               st_next.left = length_i;
               st_next.st   = S_VEC;
            end
         end
         S_VEC:
         begin
            st_next.fcnt = PDW_CNT_RST;
            st_next.st   = S_XFER;
         end
         S_XFER:
         begin
            if (issue)
            begin
               st_next.pend = 1'b1;
            end
            if (st_reg.pend && bus.ack)
            begin
               st_next.pend   = 1'b0;
               st_next.addr   = st_reg.addr + 10'h001;
               st_next.left   = st_reg.left - 11'h001;
               st_next.fcnt   = st_reg.fcnt + 10'h001;
               st_next.rdata  = bus.rdata;
               st_next.rvalid = !st_reg.we;
            end
            else if (!st_reg.pend && !issue)
            begin
               st_next.st = (st_reg.left == 11'h000) ? S_DONE : S_GAP;
            end
         end
         S_GAP:
         begin
            st_next.st = S_VEC;
         end
         S_DONE:
         begin
            st_next.st = S_IDLE;
         end
      endcase
      if (sys_rst_i)
      begin
         st_next    = '0;
         st_next.st = S_IDLE;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      st_reg <= st_next;
   end

   assign bus.cyc     = (st_reg.st == S_VEC) || (st_reg.st == S_XFER);
   assign bus.host_id = host_id_i;
   assign bus.vec_we  = (st_reg.st == S_VEC);
   assign bus.mem_req = st_reg.pend;
   assign bus.mem_we  = st_reg.we;
   assign bus.addr    = PDW_WIN_BASE | {6'h00, st_reg.addr};
   assign bus.wdata   = (st_reg.st == S_VEC) ? st_reg.page : wr_data_i;
   assign wr_take_o   = st_reg.pend && bus.ack && st_reg.we;
   assign rd_data_o   = st_reg.rdata;
   assign rd_valid_o  = st_reg.rvalid;
   assign busy_o      = (st_reg.st != S_IDLE);
   assign done_o      = (st_reg.st == S_DONE);
endmodule
`default_nettype wire

// ---- pdw_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module pdw_checker
(
   input wire logic        mclk_i,
   input wire logic        sys_rst_i,
   input wire logic        cyc,
   input wire logic        vec_we,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic [15:0] addr,
   input wire logic [7:0]  wdata,
   input wire logic [7:0]  rdata,
   input wire logic        rdata_oe_n,
   input wire logic        ack,
   input wire logic [7:0]  page_switch_i,
   input wire logic [2:0]  frame_code_i
);
   logic [7:0]  vec_reg;
   logic [10:0] cnt_reg;
   logic [10:0] fsz;
   logic        hit;
   assign fsz = 11'h010 << frame_code_i;
   assign hit = cyc && mem_req && vec_reg == page_switch_i && addr[15:10] == 6'h3D;
   // Shadow of the page vector, loaded by the same bus writes
   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i || !cyc)
         cnt_reg <= 11'h000;
      else if (ack)
         cnt_reg <= cnt_reg + 11'h001;
      if (sys_rst_i)
         vec_reg <= 8'h00;
      else if (cyc && vec_we)
         vec_reg <= wdata;
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   AST_ACK_ONE: assert property (ack |=> !ack)
      else $error("ack too long");
   AST_ACK_CAUSE: assert property (ack |-> $past(hit))
      else $error("ack without selected request");
   // Bound covers a lost arbitration round against the local port
   AST_ANSWER: assert property (hit && !ack && cnt_reg < fsz |-> ##[1:4] ack)
      else $error("request not answered");
   AST_WIN: assert property (ack |-> $past(addr) inside {[16'hF400:16'hF7FF]})
      else $error("ack outside window");
   AST_FRAME: assert property (ack |-> cnt_reg < fsz)
      else $error("frame overrun");
   AST_OE: assert property (!rdata_oe_n |-> ack && !$past(mem_we))
      else $error("read data driven out of turn");
   AST_RDATA: assert property ($changed(rdata) |-> ack && !$past(mem_we))
      else $error("read data changed");
   AST_RST: assert property (disable iff (1'b0) sys_rst_i |=> !ack && rdata_oe_n)
      else $error("not idle after reset");
   cover property (ack && mem_we);
   cover property (ack && !mem_we);
   cover property (ack && cnt_reg == fsz - 11'h001);
endmodule
`default_nettype wire

// ---- paged_dual_port_host_window_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module paged_dual_port_host_window_bench;
   logic        clk = 0;
   logic        rst = 1;
   logic        st = 0;
   logic        wr = 0;
   logic        lq = 0;
   logic        lw = 0;
   logic        tk, rv, dn, la;
   logic [1:0]  hid = 0;
   logic [2:0]  fc = 0;
   logic [9:0]  off = 0;
   logic [10:0] len = 0;
   logic [7:0]  rd, lr, d;
   logic [7:0]  wb = 0;
   logic [7:0]  wc = 0;
   logic [3:0]  fd;
   logic        bz;
   logic [7:0]  pg = 8'h03;
   logic [7:0]  pg2 = 8'h07;
   logic [9:0]  lad = 10'h3FF;
   logic [7:0]  lwd = 8'hA5;
   logic [7:0]  q[$];
   int          error_cnt = 0;
   int          tests_run = 0;
   int          fn = 0;
   int          cyc_n = 0;
   pdw_if bif();
   pdw_if bif2();
   always #20 clk = ~clk;
   pdw_device pdw_device_i (.mclk_i(clk), .sys_rst_i(rst), .bus(bif), .page_switch_i(pg),
      .frame_code_i(fc), .loc_req_i(lq), .loc_we_i(lw), .loc_addr_i(lad),
      .loc_wdata_i(lwd), .loc_rdata_o(lr), .loc_ack_o(la), .frame_done_o(fd));
   // Second module on its own bus, driven by hand to misbehave
   pdw_device pdw_device_i2 (.mclk_i(clk), .sys_rst_i(rst), .bus(bif2), .page_switch_i(pg2),
      .frame_code_i(fc), .loc_req_i(1'b0), .loc_we_i(1'b0), .loc_addr_i(10'h000),
      .loc_wdata_i(8'h00), .loc_rdata_o(), .loc_ack_o(), .frame_done_o());
   pdw_host pdw_host_i (.mclk_i(clk), .sys_rst_i(rst), .bus(bif), .host_id_i(hid),
      .start_i(st), .write_i(wr), .interface_number_i(pg), .offset_i(off), .length_i(len),
      .frame_code_i(fc), .wr_data_i(wb + wc), .wr_take_o(tk), .rd_data_o(rd),
      .rd_valid_o(rv), .busy_o(bz), .done_o(dn));
   pdw_checker pdw_checker_i (.mclk_i(clk), .sys_rst_i(rst), .cyc(bif.cyc),
      .vec_we(bif.vec_we), .mem_req(bif.mem_req), .mem_we(bif.mem_we), .addr(bif.addr),
      .wdata(bif.wdata), .rdata(bif.rdata), .rdata_oe_n(bif.rdata_oe_n), .ack(bif.ack),
      .page_switch_i(pg), .frame_code_i(fc));
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e)
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      if (g !== e)
         error_cnt++;
   endtask
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   task automatic complete_run();
      $display("Mismatches %0d, comparisons %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [1:0] h, input logic [9:0] o,
                       input logic [10:0] n);
      tick();
      wr = w;
      hid = h;
      off = o;
      len = n;
      wc = 0;
      fn = 0;
      q = {};
      st = 1;
      tick();
      st = 0;
      chk(8'(bz), 8'h01);
      do tick(); while (dn !== 1'b1);
      // Frame-end pulse trails done by one cycle and is counted on the edge after
      repeat (2) tick();
      chk(8'(bz), 8'h00);
   endtask
   task automatic lacc(input logic w);
      lw = w;
      lq = 1;
      do tick(); while (la !== 1'b1);
      d = lr;
      tick();
      lq = 0;
   endtask
   task automatic frames_all();
      for (int c = 0; c < 6; c++)
      begin
         fc = 3'(c);
         wb = 8'(c * 37);
         xfer(1'b1, 2'(c), 10'h000, 11'(16 << c) + 11'h001);
         chk(8'(fn), 8'h02);
         xfer(1'b0, 2'(c + 1), 10'h000, 11'(16 << c) + 11'h001);
         chk(8'(fn), 8'h02);
         chk(8'(q.size() == (16 << c) + 1), 8'h01);
         for (int i = 0; i < q.size(); i++) chk(q[i], wb + 8'(i));
      end
   endtask
   task automatic local_mix();
      wb = 8'h11;
      fork
         xfer(1'b1, 2'h2, 10'h000, 11'h3FF);
         begin
            repeat (20) tick();
            lacc(1'b1);
         end
      join
      xfer(1'b0, 2'h3, 10'h3FE, 11'h002);
      chk(q[0], 8'h0F);
      chk(q[1], 8'hA5);
      lacc(1'b0);
      chk(d, 8'hA5);
   endtask
   task automatic refuse();
      int a;
      a = 0;
      bif2.cyc = 1;
      bif2.vec_we = 1;
      bif2.wdata = 8'h03;
      tick();
      bif2.vec_we = 0;
      bif2.mem_req = 1;
      for (int i = 0; i < 8; i++)
      begin
         tick();
         a = a | int'(bif2.ack);
      end
      bif2.mem_req = 0;
      chk(8'(a), 8'h00);
      bif2.vec_we = 1;
      bif2.wdata = 8'h07;
      tick();
      bif2.vec_we = 0;
      bif2.addr = 16'hF800;
      bif2.mem_req = 1;
      for (int i = 0; i < 4; i++)
      begin
         tick();
         a = a | int'(bif2.ack);
      end
      bif2.mem_req = 0;
      chk(8'(a), 8'h00);
      tick();
      bif2.addr = 16'hF400;
      bif2.mem_req = 1;
      for (int i = 0; i < 4 && a == 0; i++)
      begin
         tick();
         a = int'(bif2.ack);
      end
      tick();
      bif2.mem_req = 0;
      bif2.cyc = 0;
      chk(8'(a), 8'h01);
   endtask
   always @(posedge clk)
   begin
      cyc_n++;
      if (tk)
         wc <= wc + 8'h01;
      if (rv)
         q.push_back(rd);
      if (|fd)
         fn++;
      if (bif.mem_req)
         chk(8'(bif.addr[15:10]), 8'h3D);
      if (cyc_n == 60000)
         error_cnt++;
      if (cyc_n == 60000)
         complete_run();
   end
   initial
   begin
      bif2.cyc = 0;
      bif2.host_id = 0;
      bif2.vec_we = 0;
      bif2.mem_req = 0;
      bif2.mem_we = 0;
      bif2.addr = 16'hF400;
      bif2.wdata = 0;
      repeat (2) @(posedge clk);
      #1;
      rst = 0;
      refuse();
      frames_all();
      local_mix();
      complete_run();
   end
endmodule
`default_nettype wire
